//--- verilog/sba_consts.svh
`ifndef SBA_CONSTS_SVH
`define SBA_CONSTS_SVH

// ************************************************************
// command/address word
// ************************************************************
`define SBA_SPACE      9'h1E5
`define SBA_FULL_MASK  4'hF
`define SBA_SEL_INT    2'h0
`define SBA_SEL_DRV    2'h1
`define SBA_SEL_MAP    2'h2

// ************************************************************
// internal register byte offsets
// ************************************************************
`define SBA_OFS_CTL    5'h04
`define SBA_OFS_STAT   5'h08
`define SBA_OFS_VA     5'h0C
`define SBA_OFS_BC     5'h10
`define SBA_OFS_CAR    5'h14
`define SBA_OFS_DIAG   5'h18

// ************************************************************
// field positions
// ************************************************************
`define SBA_CTL_IBC    4
`define SBA_CTL_MAINT  3
`define SBA_CTL_IE     2
`define SBA_CTL_ABORT  1
`define SBA_CTL_INIT   0
`define SBA_ST_BUSY    31
`define SBA_ST_PGE     19
`define SBA_ST_DTCMP   13
`define SBA_ST_DTABT   12
`define SBA_ST_DLT     11
`define SBA_ST_WCKU    10
`define SBA_ST_WCKL    9
`define SBA_ST_INVALID_PAGE_MAP_FLAG  4
`define SBA_DG_WCK     0
`define SBA_DG_CMD_HI  5
`define SBA_DG_CMD_LO  4
`define SBA_DG_OVF     8
`define SBA_CMD_RD     2'h1
`define SBA_CMD_WR     2'h2
`define SBA_MAP_VALID  31
`define SBA_MAP_KEEP   32'h80007FFF

// ************************************************************
// data path sizing and timing
// ************************************************************
`define SBA_BUF_DEPTH  16
`define SBA_LW_BYTES   16'h0004
`define SBA_VA_STEP    17'h00004
`define SBA_CLK_MHZ    100
`define SBA_BURST_NS   900
`define SBA_BURST_CYC  ((`SBA_BURST_NS * `SBA_CLK_MHZ) / 1000)

`endif

//--- verilog/sba_pkg.sv
package sba_pkg;
	typedef enum logic [2:0] {H_IDLE, H_MAP, H_MAPR, H_DRV, H_DRVW} sba_host_e;
	typedef enum logic [3:0] {X_IDLE, X_MAP, X_CHK, X_RUN, X_POP2, X_MWR, X_MRD,
		X_PUSH2, X_DRAIN, X_END} sba_xfer_e;
	typedef enum logic [1:0] {DIR_RD, DIR_WR, DIR_WCK} sba_dir_e;

	typedef struct packed {
		logic ibc;
		logic maint;
		logic ie;
		logic abort;
	} sba_ctl_s;

	typedef struct packed {
		logic busy;
		logic programming_error_flag;
		logic dtcmp;
		logic dtabt;
		logic dlt;
		logic wcku;
		logic wckl;
		logic invalid_page_map_flag;
	} sba_stat_s;

	typedef struct packed {
		logic [1:0]  num;
		logic        reg_ack;
		logic [15:0] reg_rdata;
		logic [15:0] data_in;
		logic        sclk;
		logic        wclk;
		logic        last;
	} sba_pin_s;

	typedef struct packed {
		sba_host_e   h;
		sba_xfer_e   x;
		sba_dir_e    dir;
		logic [31:0] ca;
		logic [31:0] wd;
		logic        wr;
		sba_ctl_s    ctl;
		sba_stat_s   st;
		logic        wck_en;
		logic        ovf;
		logic        killed;
		logic [16:0] va;
		logic [15:0] bc;
		logic [14:0] pfn;
		logic [15:0] lo;
		logic        rsp;
		logic        nore;
		logic        ready;
		logic [31:0] rdata;
		logic        drv_req;
		logic        drv_wr;
		logic [7:0]  drv_sel;
		logic [15:0] drv_wd;
		logic [15:0] dout;
		logic        detach;
		logic        mreq;
		logic        mwr;
		logic [23:0] maddr;
		logic [31:0] mwd;
		logic        irq;
	} sba_core_s;
endpackage

//--- verilog/sba_map_ram.sv
`timescale 1ns/10ps
module sba_map_ram (
	input  wire logic        clk,
	input  wire logic        we,
	input  wire logic [7:0]  addr,
	input  wire logic [31:0] wdata,
	output logic      [31:0] rdata
);
	logic [31:0] mem [256];

	// no reset: software must load every entry before use
	always_ff @(posedge clk) begin
		if (we) begin
			mem[addr] <= wdata;
		end
		rdata <= mem[addr];
	end
endmodule // sba_map_ram

//--- verilog/sba_word_buf.sv
`timescale 1ns/10ps
`include "sba_consts.svh"
module sba_word_buf (
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        flush,
	input  wire logic        push,
	input  wire logic [15:0] din,
	input  wire logic        pop,
	output logic      [15:0] head,
	output logic             full,
	output logic             empty,
	output logic             two,
	output logic             room2
);
	logic [15:0] mem [`SBA_BUF_DEPTH];
	logic [3:0]  wp_q, wp_d, rp_q, rp_d;
	logic [4:0]  cnt_q, cnt_d;
	logic        push_ok, pop_ok;

	assign full    = (cnt_q == 5'h10);
	assign empty   = (cnt_q == 5'h00);
	assign two     = (cnt_q >= 5'h02);
	assign room2   = (cnt_q <= 5'h0E);
	assign head    = mem[rp_q];
	assign push_ok = push & ~full;
	assign pop_ok  = pop & ~empty;

	always_comb begin
		wp_d  = wp_q + {3'h0, push_ok};
		rp_d  = rp_q + {3'h0, pop_ok};
		cnt_d = cnt_q + {4'h0, push_ok} - {4'h0, pop_ok};
		if (flush) begin
			wp_d  = 4'h0;
			rp_d  = 4'h0;
			cnt_d = 5'h00;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wp_q  <= 4'h0;
			rp_q  <= 4'h0;
			cnt_q <= 5'h00;
		end else begin
			wp_q  <= wp_d;
			rp_q  <= rp_d;
			cnt_q <= cnt_d;
		end
	end

	always_ff @(posedge clk) begin
		if (push_ok) begin
			mem[wp_q] <= din;
		end
	end
endmodule // sba_word_buf

//--- verilog/sba_top.sv
`timescale 1ns/10ps
`include "sba_consts.svh"
module sba_top import sba_pkg::*; (
	input  wire logic        CLOCK,
	input  wire logic        RST_N,
	input  wire logic        HOST_REQ,
	input  wire logic        HOST_WRITE,
	input  wire logic [31:0] HOST_CMD_ADDR,
	input  wire logic [31:0] HOST_WDATA,
	output logic             HOST_READY,
	output logic             HOST_RSP,
	output logic             HOST_NORESP,
	output logic      [31:0] HOST_RDATA,
	input  wire logic [1:0]  ADAPTER_NUM,
	output logic             DRV_REG_REQ,
	output logic             DRV_REG_WRITE,
	output logic      [7:0]  DRV_REG_SEL,
	output logic      [15:0] DRV_REG_WDATA,
	input  wire logic        DRV_REG_ACK,
	input  wire logic [15:0] DRV_REG_RDATA,
	input  wire logic [15:0] DRV_DATA_IN,
	input  wire logic        DRV_SYNC_CLK,
	input  wire logic        DRV_WRITE_CLK,
	input  wire logic        DRV_LAST,
	output logic      [15:0] DRV_DATA_OUT,
	output logic             DRV_DETACH,
	output logic             MEM_REQ,
	output logic             MEM_WRITE,
	output logic      [23:0] MEM_ADDR,
	output logic      [31:0] MEM_WDATA,
	input  wire logic        MEM_ACK,
	input  wire logic [31:0] MEM_RDATA,
	output logic             IRQ
);
	// ************************************************************
	// pin synchronisers
	// ************************************************************
	sba_pin_s    pin_raw, s1_q, s2_q, s3_q;
	logic        sclk_rise, wclk_rise;

	assign pin_raw = {ADAPTER_NUM, DRV_REG_ACK, DRV_REG_RDATA, DRV_DATA_IN,
		DRV_SYNC_CLK, DRV_WRITE_CLK, DRV_LAST};

	always_ff @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N) begin
			s1_q <= '0;
			s2_q <= '0;
			s3_q <= '0;
		end else begin
			s1_q <= pin_raw;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end

	// data words are stable well before their strobe edge is seen
	assign sclk_rise = s2_q.sclk & ~s3_q.sclk;
	assign wclk_rise = s2_q.wclk & ~s3_q.wclk;

	// ************************************************************
	// map memory and word buffer
	// ************************************************************
	sba_core_s   c_q, c_d;
	logic        ram_we;
	logic [7:0]  ram_addr;
	logic [31:0] ram_wd, ram_rd;
	logic        b_flush, b_push, b_pop, b_full, b_empty, b_two, b_room2;
	logic [15:0] b_din, b_head;

	sba_map_ram u_map (
		.clk   (CLOCK),
		.we    (ram_we),
		.addr  (ram_addr),
		.wdata (ram_wd),
		.rdata (ram_rd)
	);

	sba_word_buf u_buf (
		.clk   (CLOCK),
		.rst_n (RST_N),
		.flush (b_flush),
		.push  (b_push),
		.din   (b_din),
		.pop   (b_pop),
		.head  (b_head),
		.full  (b_full),
		.empty (b_empty),
		.two   (b_two),
		.room2 (b_room2)
	);

	// ************************************************************
	// host decode, registers and transfer engine
	// ************************************************************
	logic [31:0] ca, wd, st_img;
	logic        mine, bad_size, do_init, kill, done;
	logic [23:0] paddr;

	assign ca       = HOST_CMD_ADDR;
	assign wd       = HOST_WDATA;
	assign mine     = ~ca[24] & (ca[23:15] == `SBA_SPACE) & (ca[14:13] == s2_q.num);
	assign bad_size = (ca[31:28] != `SBA_FULL_MASK) | (ca[1:0] != 2'h0);
	assign kill     = c_q.ctl.abort | c_q.killed;
	assign done     = (c_q.bc == 16'h0000) & ~c_q.ctl.ibc;
	assign paddr    = {c_q.pfn, c_q.va[8:0]};

	always_comb begin
		st_img = 32'h0;
		st_img[`SBA_ST_BUSY]   = c_q.st.busy;
		st_img[`SBA_ST_PGE]    = c_q.st.programming_error_flag;
		st_img[`SBA_ST_DTCMP]  = c_q.st.dtcmp;
		st_img[`SBA_ST_DTABT]  = c_q.st.dtabt;
		st_img[`SBA_ST_DLT]    = c_q.st.dlt;
		st_img[`SBA_ST_WCKU]   = c_q.st.wcku;
		st_img[`SBA_ST_WCKL]   = c_q.st.wckl;
		st_img[`SBA_ST_INVALID_PAGE_MAP_FLAG] = c_q.st.invalid_page_map_flag;
	end

	always_comb begin
		c_d      = c_q;
		c_d.rsp  = 1'b0;
		c_d.nore = 1'b0;
		ram_we   = 1'b0;
		ram_addr = c_q.va[16:9];
		ram_wd   = 32'h0;
		b_flush  = 1'b0;
		b_push   = 1'b0;
		b_pop    = 1'b0;
		b_din    = s2_q.data_in;
		do_init  = 1'b0;
		case (c_q.h)
			H_IDLE: if (HOST_REQ && mine) begin
				c_d.ca  = ca;
				c_d.wd  = wd;
				c_d.wr  = HOST_WRITE;
				c_d.rsp = 1'b1;
				c_d.rdata = 32'h0;
				if (bad_size) begin
					c_d.nore = 1'b1;
				end else begin
					case (ca[11:10])
						`SBA_SEL_INT: if (ca[9:5] != 5'h00) begin
							c_d.nore = 1'b1;
						end else if (!HOST_WRITE) begin
							case (ca[4:0])
								`SBA_OFS_CTL:  c_d.rdata = {27'h0, c_q.ctl, 1'b0};
								`SBA_OFS_STAT: c_d.rdata = st_img;
								`SBA_OFS_VA:   c_d.rdata = {15'h0, c_q.va};
								`SBA_OFS_BC:   c_d.rdata = {16'h0, c_q.bc};
								`SBA_OFS_CAR:  c_d.rdata = {8'h00, c_q.maddr};
								`SBA_OFS_DIAG: c_d.rdata = {23'h0, c_q.ovf, 7'h00, c_q.wck_en};
								default:       c_d.nore = 1'b1;
							endcase
						end else begin
							case (ca[4:0])
								`SBA_OFS_CTL: begin
									c_d.ctl.ibc   = wd[`SBA_CTL_IBC];
									c_d.ctl.ie    = wd[`SBA_CTL_IE];
									c_d.ctl.abort = wd[`SBA_CTL_ABORT];
									if (wd[`SBA_CTL_MAINT] && !c_q.ctl.maint && c_q.st.busy) begin
										c_d.st.programming_error_flag = 1'b1;
									end else begin
										c_d.ctl.maint = wd[`SBA_CTL_MAINT];
									end
									do_init = wd[`SBA_CTL_INIT];
								end
								`SBA_OFS_STAT: begin
									c_d.st.programming_error_flag    = c_q.st.programming_error_flag & ~wd[`SBA_ST_PGE];
									c_d.st.dtcmp  = c_q.st.dtcmp & ~wd[`SBA_ST_DTCMP];
									c_d.st.dtabt  = c_q.st.dtabt & ~wd[`SBA_ST_DTABT];
									c_d.st.dlt    = c_q.st.dlt & ~wd[`SBA_ST_DLT];
									c_d.st.wcku   = c_q.st.wcku & ~wd[`SBA_ST_WCKU];
									c_d.st.wckl   = c_q.st.wckl & ~wd[`SBA_ST_WCKL];
									c_d.st.invalid_page_map_flag = c_q.st.invalid_page_map_flag & ~wd[`SBA_ST_INVALID_PAGE_MAP_FLAG];
								end
								`SBA_OFS_VA, `SBA_OFS_BC: if (c_q.st.busy) begin
									c_d.st.programming_error_flag = 1'b1;
								end else if (ca[4:0] == `SBA_OFS_VA) begin
									c_d.va = wd[16:0];
								end else begin
									c_d.bc = wd[15:0];
								end
								`SBA_OFS_CAR: ;
								`SBA_OFS_DIAG: begin
									c_d.wck_en = wd[`SBA_DG_WCK];
									c_d.ovf    = c_q.ovf & ~wd[`SBA_DG_OVF];
									if (wd[`SBA_DG_CMD_HI:`SBA_DG_CMD_LO] == `SBA_CMD_RD ||
										wd[`SBA_DG_CMD_HI:`SBA_DG_CMD_LO] == `SBA_CMD_WR) begin
										if (c_q.st.busy) begin
											c_d.st.programming_error_flag = 1'b1;
										end else begin
											c_d.st      = '0;
											c_d.st.busy = 1'b1;
											c_d.killed  = 1'b0;
											c_d.x       = X_MAP;
											b_flush     = 1'b1;
											if (wd[`SBA_DG_CMD_HI:`SBA_DG_CMD_LO] == `SBA_CMD_RD) begin
												c_d.dir = DIR_RD;
											end else if (wd[`SBA_DG_WCK]) begin
												c_d.dir = DIR_WCK;
											end else begin
												c_d.dir = DIR_WR;
											end
										end
									end
								end
								default: c_d.nore = 1'b1;
							endcase
						end
						`SBA_SEL_DRV: begin
							c_d.rsp     = 1'b0;
							c_d.drv_req = 1'b1;
							c_d.drv_wr  = HOST_WRITE;
							c_d.drv_sel = ca[9:2];
							c_d.drv_wd  = wd[15:0];
							c_d.h       = H_DRV;
						end
						`SBA_SEL_MAP: begin
							c_d.rsp = 1'b0;
							c_d.h   = H_MAP;
						end
						default: c_d.nore = 1'b1;
					endcase
				end
			end
			// engine owns the map port during its lookup cycle
			H_MAP: if (c_q.x != X_MAP) begin
				ram_addr = c_q.ca[9:2];
				if (c_q.wr) begin
					if (c_q.st.busy && !c_q.ctl.ibc) begin
						c_d.st.programming_error_flag = 1'b1;
					end else begin
						ram_we = 1'b1;
						ram_wd = c_q.wd & `SBA_MAP_KEEP;
					end
					c_d.rsp   = 1'b1;
					c_d.rdata = 32'h0;
					c_d.h     = H_IDLE;
				end else begin
					c_d.h = H_MAPR;
				end
			end
			H_MAPR: begin
				c_d.rsp   = 1'b1;
				c_d.rdata = ram_rd;
				c_d.h     = H_IDLE;
			end
			H_DRV: if (s2_q.reg_ack) begin
				c_d.drv_req = 1'b0;
				c_d.rsp     = 1'b1;
				c_d.rdata   = {16'h0, s2_q.reg_rdata};
				c_d.h       = H_DRVW;
			end
			H_DRVW: if (!s2_q.reg_ack) begin
				c_d.h = H_IDLE;
			end
			default: c_d.h = H_IDLE;
		endcase

		if (do_init) begin
			c_d.ctl    = '0;
			c_d.st     = '0;
			c_d.wck_en = 1'b0;
			c_d.ovf    = 1'b0;
			c_d.x      = X_IDLE;
			c_d.mreq   = 1'b0;
			b_flush    = 1'b1;
		end else begin
			// drive side of the word stream
			if (c_q.st.busy) begin
				if (c_q.dir == DIR_RD && sclk_rise) begin
					if (b_full) begin
						c_d.st.dlt = 1'b1;
						c_d.killed = 1'b1;
					end else begin
						b_push = 1'b1;
					end
				end else if (c_q.dir == DIR_WR && wclk_rise) begin
					if (b_empty) begin
						c_d.st.dlt = 1'b1;
						c_d.killed = 1'b1;
					end else begin
						c_d.dout = b_head;
						b_pop    = 1'b1;
					end
				end else if (c_q.dir == DIR_WCK && sclk_rise) begin
					if (b_empty) begin
						c_d.st.dlt = 1'b1;
						c_d.killed = 1'b1;
					end else begin
						b_pop = 1'b1;
						if (b_head[15:8] != s2_q.data_in[15:8]) begin
							c_d.st.wcku = 1'b1;
							c_d.killed  = 1'b1;
						end
						if (b_head[7:0] != s2_q.data_in[7:0]) begin
							c_d.st.wckl = 1'b1;
							c_d.killed  = 1'b1;
						end
					end
				end
			end
			case (c_q.x)
				X_IDLE: ;
				X_MAP: c_d.x = X_CHK;
				X_CHK: if (!ram_rd[`SBA_MAP_VALID] && c_q.bc != 16'h0000) begin
					c_d.st.invalid_page_map_flag = 1'b1;
					c_d.killed    = 1'b1;
					c_d.x         = X_END;
				end else begin
					c_d.pfn = ram_rd[14:0];
					c_d.x   = X_RUN;
				end
				X_RUN: if (kill) begin
					c_d.killed = 1'b1;
					c_d.x      = X_END;
				end else if (c_q.dir == DIR_RD) begin
					if (done || (s2_q.last && !b_two)) begin
						c_d.x = X_END;
					end else if (b_two) begin
						c_d.lo = b_head;
						b_pop  = 1'b1;
						c_d.x  = X_POP2;
					end
				end else if (done) begin
					c_d.x = X_DRAIN;
				end else if (s2_q.last) begin
					c_d.x = X_END;
				end else if (b_room2) begin
					c_d.mreq  = 1'b1;
					c_d.mwr   = 1'b0;
					c_d.maddr = paddr;
					c_d.x     = X_MRD;
				end
				X_POP2: begin
					b_pop     = 1'b1;
					c_d.mreq  = 1'b1;
					c_d.mwr   = 1'b1;
					c_d.maddr = paddr;
					c_d.mwd   = {b_head, c_q.lo};
					c_d.x     = X_MWR;
				end
				X_MWR, X_MRD: if (MEM_ACK) begin
					c_d.mreq = 1'b0;
					c_d.x    = X_RUN;
					if (c_q.x == X_MRD) begin
						b_din  = MEM_RDATA[15:0];
						b_push = 1'b1;
						c_d.lo = MEM_RDATA[31:16];
						c_d.x  = X_PUSH2;
					end
					// counters stay frozen once abort is requested
					if (!c_q.ctl.abort) begin
						c_d.va = c_q.va + `SBA_VA_STEP;
						c_d.bc = c_q.bc - `SBA_LW_BYTES;
						if (c_q.bc[15:2] == 14'h0000 && c_q.ctl.ibc) begin
							c_d.ovf = 1'b1;
						end
						if (c_d.va[8:0] == 9'h000 && c_q.x == X_MWR) begin
							c_d.x = X_MAP;
						end
					end
				end
				X_PUSH2: begin
					b_din  = c_q.lo;
					b_push = 1'b1;
					c_d.x  = (c_q.va[8:0] == 9'h000) ? X_MAP : X_RUN;
				end
				X_DRAIN: if (kill) begin
					c_d.killed = 1'b1;
					c_d.x      = X_END;
				end else if (b_empty || s2_q.last) begin
					c_d.x = X_END;
				end
				X_END: begin
					c_d.st.busy  = 1'b0;
					c_d.st.dtcmp = 1'b1;
					c_d.st.dtabt = c_d.st.dtabt | c_q.killed;
					c_d.x        = X_IDLE;
				end
				default: c_d.x = X_IDLE;
			endcase
		end

		c_d.ready  = (c_d.h == H_IDLE);
		c_d.detach = c_d.ctl.maint;
		c_d.irq    = c_d.ctl.ie & (c_d.st.programming_error_flag | c_d.st.dtcmp | c_d.st.dtabt |
			c_d.st.invalid_page_map_flag | c_d.ovf | c_d.ctl.abort);
	end

	always_ff @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N) begin
			c_q <= '0;
		end else begin
			c_q <= c_d;
		end
	end

	assign HOST_READY    = c_q.ready;
	assign HOST_RSP      = c_q.rsp;
	assign HOST_NORESP   = c_q.nore;
	assign HOST_RDATA    = c_q.rdata;
	assign DRV_REG_REQ   = c_q.drv_req;
	assign DRV_REG_WRITE = c_q.drv_wr;
	assign DRV_REG_SEL   = c_q.drv_sel;
	assign DRV_REG_WDATA = c_q.drv_wd;
	assign DRV_DATA_OUT  = c_q.dout;
	assign DRV_DETACH    = c_q.detach;
	assign MEM_REQ       = c_q.mreq;
	assign MEM_WRITE     = c_q.mwr;
	assign MEM_ADDR      = c_q.maddr;
	assign MEM_WDATA     = c_q.mwd;
	assign IRQ           = c_q.irq;
endmodule // sba_top

//--- tb/sba_monitor.sv
`timescale 1ns/10ps
module sba_monitor (
	input wire logic        CLOCK,
	input wire logic        RST_N,
	input wire logic        HOST_REQ,
	input wire logic        HOST_WRITE,
	input wire logic [31:0] HOST_CMD_ADDR,
	input wire logic [31:0] HOST_WDATA,
	input wire logic        HOST_READY,
	input wire logic        HOST_RSP,
	input wire logic        HOST_NORESP,
	input wire logic [31:0] HOST_RDATA,
	input wire logic [1:0]  ADAPTER_NUM,
	input wire logic        DRV_DETACH,
	input wire logic        MEM_REQ,
	input wire logic        MEM_ACK,
	input wire logic        MEM_WRITE,
	input wire logic [23:0] MEM_ADDR,
	input wire logic        IRQ
);
	// ********************
	// request decode
	// ********************
	logic [31:0] ca;
	logic        take, ctl, map_rd_q, map_rd_d;
	assign ca = HOST_CMD_ADDR;
	assign take = HOST_REQ & HOST_READY & ~ca[24] & (ca[23:15] == 9'h1E5)
		& (ca[14:13] == ADAPTER_NUM);
	assign ctl = take & (ca[31:28] == 4'hF) & (ca[11:0] == 12'h004);
	// map read answers come late, so remember one is pending
	always_comb begin
		map_rd_d = map_rd_q;
		if (HOST_RSP)
			map_rd_d = 1'h0;
		if (take && !HOST_WRITE && ca[11:10] == 2'h2)
			map_rd_d = 1'h1;
	end
	always_ff @(posedge CLOCK or negedge RST_N)
		if (!RST_N)
			map_rd_q <= 1'h0;
		else
			map_rd_q <= map_rd_d;
	default clocking @(posedge CLOCK); endclocking
	default disable iff (!RST_N);
	// ********************
	// checks
	// ********************
	a_odd_access: assert property (
		take && (ca[31:28] != 4'hF || ca[1:0] != 2'h0) |=> HOST_RSP && HOST_NORESP)
		else $error("odd access answered with data");
	a_target_three: assert property (
		take && ca[11:10] == 2'h3 |=> HOST_RSP && HOST_NORESP)
		else $error("target 3 answered with data");
	a_hole_offset: assert property (
		take && ca[31:28] == 4'hF && ca[1:0] == 2'h0 && ca[11:10] == 2'h0
		&& (ca[9:5] != 5'h0 || ca[4:2] == 3'h0 || ca[4:2] == 3'h7)
		|=> HOST_RSP && HOST_NORESP)
		else $error("missing register answered with data");
	a_foreign_space: assert property (
		HOST_REQ && HOST_READY && (ca[23:15] != 9'h1E5 || ca[24]) |=> !HOST_RSP)
		else $error("foreign space answered");
	a_other_adapter: assert property (
		HOST_REQ && HOST_READY && ca[14:13] != ADAPTER_NUM |=> !HOST_RSP)
		else $error("other adapter number answered");
	a_ctl_read_zero: assert property (
		ctl && !HOST_WRITE |=> HOST_RSP && !HOST_NORESP && HOST_RDATA[31:5] == 27'h0
		&& !HOST_RDATA[0])
		else $error("control readback has set reserved or init bits");
	a_init_clears: assert property (
		ctl && HOST_WRITE && HOST_WDATA[0] ##1 !HOST_REQ |=> !IRQ && !DRV_DETACH && !MEM_REQ)
		else $error("init left activity behind");
	a_noresp_pulse: assert property (
		HOST_NORESP |-> HOST_RSP)
		else $error("no-response flag without answer strobe");
	a_mem_hold: assert property (
		MEM_REQ && !MEM_ACK && !(ctl && HOST_WRITE && HOST_WDATA[0])
		|=> MEM_REQ && $stable(MEM_ADDR) && $stable(MEM_WRITE))
		else $error("memory request changed before acknowledge");
	a_map_reserved: assert property (
		HOST_RSP && !HOST_NORESP && map_rd_q |-> HOST_RDATA[30:15] == 16'h0)
		else $error("map entry reserved bits not zero");
endmodule // sba_monitor

bind sba_top sba_monitor mon (.CLOCK(CLOCK), .RST_N(RST_N), .HOST_REQ(HOST_REQ),
	.HOST_WRITE(HOST_WRITE), .HOST_CMD_ADDR(HOST_CMD_ADDR), .HOST_WDATA(HOST_WDATA),
	.HOST_READY(HOST_READY), .HOST_RSP(HOST_RSP), .HOST_NORESP(HOST_NORESP),
	.HOST_RDATA(HOST_RDATA), .ADAPTER_NUM(ADAPTER_NUM), .DRV_DETACH(DRV_DETACH),
	.MEM_REQ(MEM_REQ), .MEM_ACK(MEM_ACK), .MEM_WRITE(MEM_WRITE), .MEM_ADDR(MEM_ADDR), .IRQ(IRQ));

//--- tb/sba_partner.sv
`timescale 1ns/10ps
module sba_partner (
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        mem_req,
	output logic             mem_ack,
	output logic      [31:0] mem_rdata,
	input  wire logic        reg_req,
	input  wire logic [7:0]  reg_sel,
	output logic             reg_ack,
	output logic      [15:0] reg_rdata,
	input  wire logic        go,
	output logic      [15:0] data,
	output logic             sclk,
	output logic             last
);
	logic [2:0] wait_q;
	logic       slow_q, pipe_q;
	// memory answers alternately at once and after a stall
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wait_q <= 3'h0;
			slow_q <= 1'h0;
			mem_ack <= 1'h0;
			pipe_q <= 1'h0;
			reg_ack <= 1'h0;
		end else begin
			mem_ack <= 1'h0;
			wait_q <= 3'h0;
			if (mem_req && !mem_ack) begin
				wait_q <= wait_q + 3'h1;
				if (wait_q >= (slow_q ? 3'h4 : 3'h0)) begin
					mem_ack <= 1'h1;
					slow_q <= !slow_q;
				end
			end
			pipe_q <= reg_req;
			reg_ack <= pipe_q;
		end
	end
	// released lines show the inverse, never the last value
	assign mem_rdata = mem_ack ? 32'h1357_9BDF : 32'hECA8_6420;
	assign reg_rdata = reg_ack ? {8'hC3, reg_sel} : ~{8'hC3, reg_sel};
	initial begin
		data = 16'hFFFF;
		sclk = 1'h0;
		last = 1'h0;
	end
	// four words at the fastest burst pace
	always @(posedge go) begin
		last = 1'h0;
		for (int i = 0; i < 4; i++) begin
			repeat (80) @(posedge clk);
			#1 data = 16'hA000 + 16'(i);
			repeat (2) @(posedge clk);
			#1 sclk = 1'h1;
			repeat (4) @(posedge clk);
			#1 sclk = 1'h0;
			repeat (4) @(posedge clk);
			#1 data = ~data;
		end
		last = 1'h1;
	end
endmodule // sba_partner

//--- tb/tb.sv
`timescale 1ns/10ps
module tb;
	typedef struct packed {
		logic [31:0] ca;
		logic        wr;
		logic [31:0] wd;
		logic        nr;
		logic [31:0] rd;
	} sba_row_s;
	logic        CLOCK, RST_N, HOST_REQ, HOST_WRITE, HOST_READY, HOST_RSP, HOST_NORESP;
	logic        DRV_REG_REQ, DRV_REG_WRITE, DRV_REG_ACK, DRV_SYNC_CLK, DRV_LAST, DRV_DETACH;
	logic        MEM_REQ, MEM_WRITE, MEM_ACK, IRQ, go, got, nr;
	logic [1:0]  ADAPTER_NUM;
	logic [7:0]  DRV_REG_SEL;
	logic [15:0] DRV_REG_WDATA, DRV_REG_RDATA, DRV_DATA_IN, DRV_DATA_OUT;
	logic [23:0] MEM_ADDR;
	logic [31:0] HOST_CMD_ADDR, HOST_WDATA, HOST_RDATA, MEM_WDATA, MEM_RDATA, rd;
	logic [63:0] mq[$];
	sba_row_s    rows[$];
	int          err_total, comparisons;
	sba_top dut (.CLOCK(CLOCK), .RST_N(RST_N), .HOST_REQ(HOST_REQ), .HOST_WRITE(HOST_WRITE),
		.HOST_CMD_ADDR(HOST_CMD_ADDR), .HOST_WDATA(HOST_WDATA), .HOST_READY(HOST_READY),
		.HOST_RSP(HOST_RSP), .HOST_NORESP(HOST_NORESP), .HOST_RDATA(HOST_RDATA),
		.ADAPTER_NUM(ADAPTER_NUM), .DRV_REG_REQ(DRV_REG_REQ), .DRV_REG_WRITE(DRV_REG_WRITE),
		.DRV_REG_SEL(DRV_REG_SEL), .DRV_REG_WDATA(DRV_REG_WDATA), .DRV_REG_ACK(DRV_REG_ACK),
		.DRV_REG_RDATA(DRV_REG_RDATA), .DRV_DATA_IN(DRV_DATA_IN), .DRV_SYNC_CLK(DRV_SYNC_CLK),
		.DRV_WRITE_CLK(1'h0), .DRV_LAST(DRV_LAST), .DRV_DATA_OUT(DRV_DATA_OUT),
		.DRV_DETACH(DRV_DETACH), .MEM_REQ(MEM_REQ), .MEM_WRITE(MEM_WRITE), .MEM_ADDR(MEM_ADDR),
		.MEM_WDATA(MEM_WDATA), .MEM_ACK(MEM_ACK), .MEM_RDATA(MEM_RDATA), .IRQ(IRQ));
	sba_partner far (.clk(CLOCK), .rst_n(RST_N), .mem_req(MEM_REQ), .mem_ack(MEM_ACK),
		.mem_rdata(MEM_RDATA), .reg_req(DRV_REG_REQ), .reg_sel(DRV_REG_SEL),
		.reg_ack(DRV_REG_ACK), .reg_rdata(DRV_REG_RDATA), .go(go), .data(DRV_DATA_IN),
		.sclk(DRV_SYNC_CLK), .last(DRV_LAST));
	always @(posedge CLOCK)
		if (MEM_REQ === 1'h1 && MEM_ACK === 1'h1 && MEM_WRITE === 1'h1)
			mq.push_back({8'h0, MEM_ADDR, MEM_WDATA});
	// ********************
	// helpers
	// ********************
	function automatic logic [31:0] a(input logic [1:0] t, input logic [9:0] l);
		return {4'hF, 4'h0, 9'h1E5, 2'h2, 1'h0, t, l};
	endfunction
	task automatic add(input logic [31:0] c, input logic w, input logic [31:0] d,
		input logic n, input logic [31:0] r);
		rows.push_back({c, w, d, n, r});
	endtask
	task automatic idle(input int n);
		repeat (n) @(posedge CLOCK);
		#1;
	endtask
	task automatic chk(input logic [63:0] g, input logic [63:0] e);
		comparisons++;
		if (g !== e) begin
			err_total++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	// one request, then wait for the strobe that answers it
	task automatic host(input logic [31:0] c, input logic w, input logic [31:0] d);
		int k;
		k = 0;
		while (HOST_READY !== 1'h1 && k < 100) begin
			idle(1);
			k++;
		end
		HOST_CMD_ADDR = c;
		HOST_WRITE = w;
		HOST_WDATA = d;
		HOST_REQ = 1'h1;
		idle(1);
		HOST_REQ = 1'h0;
		got = 1'h0;
		for (k = 0; k < 40 && !got; k++) begin
			if (HOST_RSP === 1'h1) begin
				got = 1'h1;
				nr = HOST_NORESP;
				rd = HOST_RDATA;
			end
			idle(1);
		end
	endtask
	task automatic report_and_stop;
		$display("comparisons=%0d err_total=%0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	initial begin
		CLOCK = 1'h0;
		forever #5 CLOCK = ~CLOCK;
	end
	initial begin
		repeat (20000) @(posedge CLOCK);
		err_total++;
		report_and_stop;
	end
	// ********************
	// sequence
	// ********************
	initial begin
		RST_N = 1'h0;
		HOST_REQ = 1'h0;
		HOST_WRITE = 1'h0;
		HOST_CMD_ADDR = 32'h0;
		HOST_WDATA = 32'h0;
		ADAPTER_NUM = 2'h2;
		go = 1'h0;
		err_total = 0;
		comparisons = 0;
		add(a(2'h0, 10'h004), 1'h1, 32'hFFFF_FFF4, 1'h0, 32'h0);
		add(a(2'h0, 10'h004), 1'h0, 32'h0, 1'h0, 32'h14);
		add(a(2'h0, 10'h004), 1'h1, 32'hB, 1'h0, 32'h0);
		add(a(2'h0, 10'h004), 1'h0, 32'h0, 1'h0, 32'h0);
		add(a(2'h0, 10'h004), 1'h1, 32'h2, 1'h0, 32'h0);
		add(a(2'h0, 10'h004), 1'h0, 32'h0, 1'h0, 32'h2);
		add(a(2'h0, 10'h004), 1'h1, 32'h0, 1'h0, 32'h0);
		add(a(2'h0, 10'h000), 1'h0, 32'h0, 1'h1, 32'h0);
		add(a(2'h0, 10'h01C), 1'h0, 32'h0, 1'h1, 32'h0);
		add(a(2'h0, 10'h024), 1'h0, 32'h0, 1'h1, 32'h0);
		add(a(2'h3, 10'h004), 1'h0, 32'h0, 1'h1, 32'h0);
		add(a(2'h0, 10'h004) & 32'h7FFF_FFFF, 1'h0, 32'h0, 1'h1, 32'h0);
		add(a(2'h0, 10'h004) | 32'h2, 1'h0, 32'h0, 1'h1, 32'h0);
		add(a(2'h2, 10'h014), 1'h1, 32'hFFFF_FFFF, 1'h0, 32'h0);
		add(a(2'h2, 10'h014), 1'h0, 32'h0, 1'h0, 32'h8000_7FFF);
		add(a(2'h2, 10'h3FC), 1'h1, 32'h1234, 1'h0, 32'h0);
		add(a(2'h2, 10'h3FC), 1'h0, 32'h0, 1'h0, 32'h1234);
		add(a(2'h1, 10'h114), 1'h1, 32'hBEEF, 1'h0, 32'hC345);
		add(a(2'h1, 10'h114), 1'h0, 32'h0, 1'h0, 32'hC345);
		repeat (8) @(posedge CLOCK);
		#1 RST_N = 1'h1;
		idle(4);
		chk(64'({HOST_READY, IRQ, DRV_DETACH, MEM_REQ, DRV_REG_REQ}), 64'h10);
		foreach (rows[i]) begin
			host(rows[i].ca, rows[i].wr, rows[i].wd);
			chk(64'({got, nr}), 64'({1'h1, rows[i].nr}));
			if (!rows[i].nr)
				chk(64'(rd), 64'(rows[i].rd));
		end
		host(a(2'h0, 10'h004), 1'h1, 32'h8);
		idle(2);
		chk(64'(DRV_DETACH), 64'h1);
		host(a(2'h0, 10'h004), 1'h1, 32'h0);
		host(a(2'h0, 10'h004) ^ 32'h0080_0000, 1'h0, 32'h0);
		chk(64'(got), 64'h0);
		host(a(2'h0, 10'h004) | 32'h0100_0000, 1'h0, 32'h0);
		chk(64'(got), 64'h0);
		host(a(2'h0, 10'h004) ^ 32'h0000_6000, 1'h0, 32'h0);
		chk(64'(got), 64'h0);
		host(a(2'h2, 10'h000), 1'h1, 32'h8000_0010);
		host(a(2'h0, 10'h00C), 1'h1, 32'h0);
		host(a(2'h0, 10'h010), 1'h1, 32'h8);
		host(a(2'h0, 10'h008), 1'h1, 32'hFFFF_FFFF);
		host(a(2'h0, 10'h018), 1'h1, 32'h10);
		go = 1'h1;
		host(a(2'h0, 10'h004), 1'h1, 32'h8);
		idle(2);
		chk(64'(DRV_DETACH), 64'h0);
		host(a(2'h0, 10'h008), 1'h0, 32'h0);
		chk(64'(rd & 32'h8008_0000), 64'h8008_0000);
		idle(700);
		chk(64'(mq.size()), 64'h2);
		chk(mq[0], {8'h0, 24'h002000, 32'hA001_A000});
		chk(mq[1], {8'h0, 24'h002004, 32'hA003_A002});
		host(a(2'h0, 10'h008), 1'h0, 32'h0);
		chk(64'(rd & 32'h8000_3800), 64'h2000);
		host(a(2'h0, 10'h008), 1'h1, 32'hFFFF_FFFF);
		host(a(2'h2, 10'h004), 1'h1, 32'h0);
		host(a(2'h0, 10'h00C), 1'h1, 32'h200);
		host(a(2'h0, 10'h010), 1'h1, 32'h4);
		host(a(2'h0, 10'h018), 1'h1, 32'h10);
		idle(20);
		host(a(2'h0, 10'h008), 1'h0, 32'h0);
		chk(64'(rd & 32'h8000_1010), 64'h1010);
		host(a(2'h0, 10'h004), 1'h1, 32'h4);
		chk(64'(IRQ), 64'h1);
		RST_N = 1'h0;
		idle(2);
		chk(64'({HOST_READY, IRQ, DRV_DETACH, MEM_REQ, DRV_REG_REQ}), 64'h0);
		RST_N = 1'h1;
		idle(4);
		report_and_stop;
	end
endmodule // tb
